// *** rtl/uart_address_recognition.sv ***
// Implementation choice: the APB interface to the registers.
module uart_address_recognition
  import addr_filter_pkg::*;
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire addr_filter_pkg::rx_frame_t rx_frame,
  output logic                            receive_done_flag,
  output addr_filter_pkg::rx_buffer_t     rx_buffer,
  output logic                            irq
);
  import addr_filter_pkg::*;

  // Masked compare shared by given and broadcast checks
  function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] pattern,
                                      input logic [7:0] care);
    addr_match = (((rx ^ pattern) & care) == 8'h00);
  endfunction

  // Register select, shared by every write decode and the read clear
  function automatic logic reg_hit(input logic strobe, input logic [11:0] addr,
                                   input logic [11:0] target);
    reg_hit = strobe && (addr == target);
  endfunction

  logic [7:0]       station_address_q, station_address_d;
  logic [7:0]       station_address_mask_q, station_address_mask_d;
  logic [1:0]       mode_q, mode_d;
  logic             filter_enable_q, filter_enable_d;
  logic             receive_done_q, receive_done_d;
  rx_buffer_t       rx_buffer_q, rx_buffer_d;
  logic [IRQ_W-1:0] irq_status_q, irq_status_d;
  logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
  logic             irq_q, irq_d;
  logic [31:0]      prdata_q, prdata_d;
  logic             pready_q, pready_d;
  logic             pslverr_q, pslverr_d;

  logic [7:0] given_pattern;
  logic [7:0] broadcast_pattern;
  logic       any_match;
  logic       filtering;
  logic       accept;
  logic       drop;
  logic       access;
  logic       finish;
  logic       mapped;
  logic [31:0] read_word;

  // Address recognition
  always_comb
  begin
    given_pattern     = station_address_q & station_address_mask_q;
    broadcast_pattern = station_address_q | station_address_mask_q;
    any_match = addr_match(rx_frame.data, given_pattern, station_address_mask_q)
              | addr_match(rx_frame.data, broadcast_pattern, broadcast_pattern);
    case (mode_q)
      MODE_SHIFT: filtering = 1'b0;
      default:    filtering = filter_enable_q;
    endcase
    accept    = 1'b0;
    if (rx_frame.valid)
    begin
      if (!filtering)
        accept = 1'b1;
      else if (mode_q == MODE_EIGHT)
        accept = rx_frame.ninth && any_match;
      else
        accept = rx_frame.ninth && any_match;
    end
    drop = rx_frame.valid && !accept;
  end

  // APB decode
  always_comb
  begin
    access = psel && penable;
    finish = access && pready_q;
    mapped = 1'b1;
    read_word = 32'h0000_0000;
    case (paddr)
      STATION_ADDRESS_ADDR:      read_word = {24'h00_0000, station_address_q};
      STATION_ADDRESS_MASK_ADDR: read_word = {24'h00_0000, station_address_mask_q};
      SERIAL_CONTROL_ADDR:
      begin
        read_word[MODE_LSB +: 2]     = mode_q;
        read_word[FILTER_ENABLE_BIT] = filter_enable_q;
        read_word[NINTH_BIT_POS]     = rx_buffer_q.ninth;
        read_word[RECEIVE_DONE_BIT]  = receive_done_q;
      end
      IRQ_STATUS_ADDR:           read_word[IRQ_W-1:0] = irq_status_q;
      IRQ_MASK_ADDR:             read_word[IRQ_W-1:0] = irq_mask_q;
      RX_DATA_ADDR:              read_word = {24'h00_0000, rx_buffer_q.data};
      default:                   mapped = 1'b0;
    endcase
  end

  // Bus answer; one wait state, with data and error registered on the same edge that raises pready
  always_comb
  begin
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    pready_d  = 1'b0;
    if (access && !pready_q)
    begin
      pready_d  = 1'b1;
      pslverr_d = !mapped;
      prdata_d  = pwrite ? 32'h0000_0000 : read_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Addresses; only the answered edge writes, so a stalled access changes nothing
  always_comb
  begin
    station_address_d      = station_address_q;
    station_address_mask_d = station_address_mask_q;
    if (reg_hit(finish && pwrite, paddr, STATION_ADDRESS_ADDR))
      station_address_d = pwdata[7:0];
    if (reg_hit(finish && pwrite, paddr, STATION_ADDRESS_MASK_ADDR))
      station_address_mask_d = pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      station_address_q      <= STATION_ADDRESS_RST;
      station_address_mask_q <= STATION_ADDRESS_MASK_RST;
    end
    else
    begin
      station_address_q      <= station_address_d;
      station_address_mask_q <= station_address_mask_d;
    end
  end

  // Mode and filter enable
  always_comb
  begin
    mode_d          = mode_q;
    filter_enable_d = filter_enable_q;
    if (reg_hit(finish && pwrite, paddr, SERIAL_CONTROL_ADDR))
    begin
      mode_d          = pwdata[MODE_LSB +: 2];
      filter_enable_d = pwdata[FILTER_ENABLE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q          <= MODE_RST;
      filter_enable_q <= 1'b0;
    end
    else
    begin
      mode_q          <= mode_d;
      filter_enable_q <= filter_enable_d;
    end
  end

  // Receive done flag; a frame in the cycle of a software clear wins
  always_comb
  begin
    receive_done_d = receive_done_q;
    if (reg_hit(finish && pwrite, paddr, SERIAL_CONTROL_ADDR) && !pwdata[RECEIVE_DONE_BIT])
      receive_done_d = 1'b0;
    if (accept)
      receive_done_d = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      receive_done_q <= 1'b0;
    end
    else
    begin
      receive_done_q <= receive_done_d;
    end
  end

  // Receive buffer; a dropped frame leaves the last accepted one in place
  always_comb
  begin
    rx_buffer_d = rx_buffer_q;
    if (accept)
    begin
      rx_buffer_d.data  = rx_frame.data;
      rx_buffer_d.ninth = rx_frame.ninth;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_buffer_q <= '{ninth: 1'b0, data: RX_DATA_RST};
    end
    else
    begin
      rx_buffer_q <= rx_buffer_d;
    end
  end

  // Interrupt mask
  always_comb
  begin
    irq_mask_d = irq_mask_q;
    if (reg_hit(finish && pwrite, paddr, IRQ_MASK_ADDR))
      irq_mask_d = pwdata[IRQ_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_mask_q <= IRQ_RST;
    end
    else
    begin
      irq_mask_q <= irq_mask_d;
    end
  end

  // Sticky status; a read clear loses to an event in the same cycle
  always_comb
  begin
    irq_status_d = irq_status_q;
    if (reg_hit(finish && !pwrite, paddr, IRQ_STATUS_ADDR))
      irq_status_d = '0;
    if (accept)
      irq_status_d[IRQ_ACCEPT_BIT] = 1'b1;
    if (drop)
      irq_status_d[IRQ_DROP_BIT] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status_q <= IRQ_RST;
    end
    else
    begin
      irq_status_q <= irq_status_d;
    end
  end

  // Interrupt line; built from next values so it rises with the status bit
  always_comb
  begin
    irq_d = |(irq_status_d & irq_mask_d);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_d;
    end
  end

  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign receive_done_flag = receive_done_q;
  assign rx_buffer         = rx_buffer_q;
  assign irq               = irq_q;

endmodule

// *** rtl/addr_filter_pkg.sv ***
package addr_filter_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  STATION_ADDRESS_IDX      = 8'ha9;
  localparam logic [7:0]  STATION_ADDRESS_MASK_IDX = 8'hb9;
  localparam logic [7:0]  SERIAL_CONTROL_IDX       = 8'hc0;
  localparam logic [7:0]  IRQ_STATUS_IDX           = 8'hc1;
  localparam logic [7:0]  IRQ_MASK_IDX             = 8'hc2;
  localparam logic [7:0]  RX_DATA_IDX              = 8'hc3;

  localparam logic [11:0] STATION_ADDRESS_ADDR      = {2'h0, STATION_ADDRESS_IDX, 2'h0};
  localparam logic [11:0] STATION_ADDRESS_MASK_ADDR = {2'h0, STATION_ADDRESS_MASK_IDX, 2'h0};
  localparam logic [11:0] SERIAL_CONTROL_ADDR       = {2'h0, SERIAL_CONTROL_IDX, 2'h0};
  localparam logic [11:0] IRQ_STATUS_ADDR           = {2'h0, IRQ_STATUS_IDX, 2'h0};
  localparam logic [11:0] IRQ_MASK_ADDR             = {2'h0, IRQ_MASK_IDX, 2'h0};
  localparam logic [11:0] RX_DATA_ADDR              = {2'h0, RX_DATA_IDX, 2'h0};

  // Reset values
  localparam logic [7:0]  STATION_ADDRESS_RST      = 8'h00;
  localparam logic [7:0]  STATION_ADDRESS_MASK_RST = 8'h00;
  localparam logic [1:0]  MODE_RST                 = 2'h0;
  localparam logic [1:0]  IRQ_RST                  = 2'h0;
  localparam logic [7:0]  RX_DATA_RST              = 8'h00;

  // Serial control register fields
  localparam int MODE_LSB             = 0;
  localparam int FILTER_ENABLE_BIT    = 2;
  localparam int NINTH_BIT_POS        = 3;
  localparam int RECEIVE_DONE_BIT     = 4;

  // Interrupt status fields
  localparam int IRQ_ACCEPT_BIT       = 0;
  localparam int IRQ_DROP_BIT         = 1;
  localparam int IRQ_W                = 2;

  // Modes
  localparam logic [1:0] MODE_SHIFT   = 2'h0;
  localparam logic [1:0] MODE_EIGHT   = 2'h1;
  localparam logic [1:0] MODE_NINE_A  = 2'h2;
  localparam logic [1:0] MODE_NINE_B  = 2'h3;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       ninth;
  } rx_frame_t;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } rx_buffer_t;

endpackage

// *** testbench/uart_address_recognition_props.sv ***
module uart_address_recognition_props
  import addr_filter_pkg::*;
(
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [11:0]                 paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire addr_filter_pkg::rx_frame_t  rx_frame,
  input wire logic                        receive_done_flag,
  input wire addr_filter_pkg::rx_buffer_t rx_buffer
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sa_q, m_q, ctl_q;
  logic [8:0] fr;
  logic       v, done, filt, given, bcast, ok;
  assign v = rx_frame.valid;
  assign fr = {rx_frame.ninth, rx_frame.data};
  assign done = psel && penable && pready;
  assign filt = ctl_q[FILTER_ENABLE_BIT] && ctl_q[1:0] != MODE_SHIFT;
  assign given = ((fr[7:0] ^ (sa_q & m_q)) & m_q) == 8'h00;
  assign bcast = ((fr[7:0] ^ (sa_q | m_q)) & (sa_q | m_q)) == 8'h00;
  assign ok = fr[8] && (given || bcast);
  // Shadow of the writes, so matches are judged without peeking inside
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sa_q <= 8'h00;
      m_q <= 8'h00;
      ctl_q <= 8'h00;
    end
    else if (done && pwrite)
    begin
      if (paddr == STATION_ADDRESS_ADDR) sa_q <= pwdata[7:0];
      if (paddr == STATION_ADDRESS_MASK_ADDR) m_q <= pwdata[7:0];
      if (paddr == SERIAL_CONTROL_ADDR) ctl_q <= pwdata[7:0];
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_given_take: assert property (v && fr[8] && given |=> rx_buffer == $past(fr))
    else $error("given frame lost");
  a_bcast_take: assert property (v && fr[8] && bcast |=> rx_buffer == $past(fr))
    else $error("broadcast frame lost");
  a_open_take: assert property (v && !filt |=> rx_buffer == $past(fr))
    else $error("unfiltered frame lost");
  a_drop_hold: assert property (v && filt && !ok |=> $stable(rx_buffer))
    else $error("dropped frame changed buffer");
  a_flag_set: assert property (v && (!filt || ok) |=> receive_done_flag)
    else $error("flag not set");
  a_flag_stay: assert property (receive_done_flag && !(done && pwrite && paddr == SERIAL_CONTROL_ADDR)
    |=> receive_done_flag)
    else $error("flag fell by itself");
  a_sa_read: assert property (done && !pwrite && paddr == STATION_ADDRESS_ADDR |-> prdata[7:0] == sa_q)
    else $error("station address read wrong");
  a_mask_read: assert property (done && !pwrite && paddr == STATION_ADDRESS_MASK_ADDR |-> prdata[7:0] == m_q)
    else $error("mask read wrong");
endmodule
bind uart_address_recognition uart_address_recognition_props props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .rx_frame, .receive_done_flag, .rx_buffer);

// *** testbench/master_node.sv ***
module master_node
  import addr_filter_pkg::*;
(
  input  wire logic                  pclk,
  output addr_filter_pkg::rx_frame_t rx_frame
);
  timeunit 1ns;
  timeprecision 100ps;
  initial rx_frame = '0;
  task automatic send(input logic [7:0] d, input logic n);
    @(posedge pclk);
    rx_frame <= '{valid: 1'b1, data: d, ninth: n};
    @(posedge pclk);
    // Inverse on idle, so stale data never looks fresh
    rx_frame <= '{valid: 1'b0, data: ~d, ninth: ~n};
  endtask
endmodule

// *** testbench/uart_address_recognition_bench.sv ***
module uart_address_recognition_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import addr_filter_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, receive_done_flag, irq, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:0]  ctl;
  rx_frame_t   rx_frame;
  rx_buffer_t  rx_buffer, bx = '0;
  int          bad_count = 0, n_tests = 0;
  always #2.5 pclk = ~pclk;
  master_node node (.pclk, .rx_frame);
  uart_address_recognition DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_frame, .receive_done_flag, .rx_buffer, .irq);
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Clears the flag first, so each frame shows its own effect
  task automatic frame(input logic [7:0] d, input logic n, input logic acc);
    apb(1'b1, SERIAL_CONTROL_ADDR, ctl);
    node.send(d, n);
    @(negedge pclk);
    if (acc) bx = '{ninth: n, data: d};
    chk("buffer", 32'(rx_buffer), 32'(bx));
    chk("flag", 32'(receive_done_flag), 32'(acc));
  endtask
  task automatic t_reset;
    apb(1'b0, STATION_ADDRESS_ADDR, 8'h00);
    chk("station", rd, 32'h0);
    apb(1'b0, STATION_ADDRESS_MASK_ADDR, 8'h00);
    chk("mask", rd, 32'h0);
    apb(1'b0, 12'h3f0, 8'h00);
    chk("slverr", 32'(err), 32'h1);
    ctl = 8'h06;
    frame(8'h5a, 1'b1, 1'b1);
  endtask
  task automatic t_given;
    apb(1'b1, STATION_ADDRESS_ADDR, 8'hc0);
    apb(1'b1, STATION_ADDRESS_MASK_ADDR, 8'hfd);
    ctl = 8'h07;
    frame(8'hc2, 1'b1, 1'b1);
    frame(8'hc1, 1'b1, 1'b0);
    frame(8'hff, 1'b1, 1'b1);
    frame(8'hc0, 1'b0, 1'b0);
  endtask
  task automatic t_modes;
    ctl = 8'h05;
    frame(8'hc0, 1'b0, 1'b0);
    frame(8'hc0, 1'b1, 1'b1);
    apb(1'b0, SERIAL_CONTROL_ADDR, 8'h00);
    chk("control", rd, 32'h1d);
    apb(1'b0, RX_DATA_ADDR, 8'h00);
    chk("rx data", rd, 32'hc0);
    ctl = 8'h04;
    frame(8'h12, 1'b0, 1'b1);
    ctl = 8'h02;
    frame(8'h13, 1'b0, 1'b1);
  endtask
  task automatic t_irq;
    apb(1'b0, IRQ_STATUS_ADDR, 8'h00);
    chk("sticky status", rd, 32'h3);
    apb(1'b1, IRQ_MASK_ADDR, 8'h01);
    frame(8'h21, 1'b0, 1'b1);
    @(negedge pclk);
    chk("irq", 32'(irq), 32'h1);
    apb(1'b0, IRQ_STATUS_ADDR, 8'h00);
    chk("status", rd, 32'h1);
    repeat (2) @(negedge pclk);
    chk("irq", 32'(irq), 32'h0);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_given();
    t_modes();
    t_irq();
    tally_and_finish();
  end
  // About 120 cycles expected; 4000 cycles, over thirty times that, is a hang
  initial
  begin
    #20000;
    bad_count++;
    tally_and_finish();
  end
endmodule
